// >>> common/bn_pkg.sv
package bn_pkg;

    // Datapath geometry
    localparam int WORD_W     = 64;
    localparam int LEN_W      = 16;
    localparam int ADDR_W     = 16;
    localparam int WORD_SHIFT = 3;

    // Operation codes
    localparam logic [6:0] OP_CARRY_ADDSUB = 7'h2a;
    localparam logic [6:0] OP_XOR          = 7'h0f;
    localparam logic [6:0] OP_TZC          = 7'h2d;
    localparam logic [6:0] OP_LZC          = 7'h2e;
    localparam logic [6:0] OP_FILL         = 7'h3e;
    localparam logic [6:0] OP_CMP          = 7'h4b;
    localparam logic [6:0] OP_MAC          = 7'h62;
    localparam logic [6:0] OP_CLMAC        = 7'h66;
    localparam logic [6:0] OP_SINGLE_WORD_MULTIPLY         = 7'h20;

    // Word size modes giving 64-bit words
    localparam logic [1:0] MODE_W64_A = 2'h0;
    localparam logic [1:0] MODE_W64_B = 2'h2;

    // Per-word phases of a multi-word operation
    localparam logic [1:0] PH_RD_Y  = 2'h0;
    localparam logic [1:0] PH_RD_Z  = 2'h1;
    localparam logic [1:0] PH_CAP_Y = 2'h2;
    localparam logic [1:0] PH_EXEC  = 2'h3;

    // Fixed-length operations
    localparam logic [4:0] ZCNT_LAST  = 5'h0f;
    localparam logic [4:0] SINGLE_WORD_MULTIPLY_LAST  = 5'h03;
    localparam logic [4:0] STEP_ISSUE = 5'h00;
    localparam logic [4:0] STEP_ISSUE2 = 5'h01;
    localparam logic [4:0] STEP_CAP   = 5'h02;
    localparam logic [3:0] ZCNT_SAT   = 4'h8;

    typedef enum logic [3:0] {
        K_NONE, K_ADD, K_SUB, K_XOR, K_TZC, K_LZC,
        K_FILL, K_CMP, K_MAC, K_CLMAC, K_SINGLE_WORD_MULTIPLY
    } bn_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } bn_state_t;

endpackage

// >>> common/bn_mul_if.sv
`timescale 1ns/10ps
interface bn_mul_if #(parameter int W = 64);
    logic [W-1:0]   a;
    logic [W-1:0]   b;
    logic           carryless;
    logic [2*W-1:0] prod;

    modport client (output a, output b, output carryless, input prod);
    modport server (input a, input b, input carryless, output prod);
endinterface

// >>> verilog/bn_mul.sv
`timescale 1ns/10ps
module bn_mul #(
    parameter int W = 64
) (
    bn_mul_if.server bus
);

    logic [2*W-1:0] int_prod;
    logic [2*W-1:0] cl_prod;

    // Integer product
    assign int_prod = {{W{1'b0}}, bus.a} * {{W{1'b0}}, bus.b};

    // Carry-less product
    always_comb begin
        cl_prod = '0;
        for (int i = 0; i < W; i++) begin
            if (bus.b[i]) begin
                cl_prod = cl_prod ^ ({{W{1'b0}}, bus.a} << i);
            end
        end
    end

    assign bus.prod = bus.carryless ? cl_prod : int_prod;

endmodule

// >>> verilog/bn_alu.sv
`timescale 1ns/10ps
module bn_alu #(
    parameter int WORD_W = bn_pkg::WORD_W,
    parameter int LEN_W  = bn_pkg::LEN_W,
    parameter int ADDR_W = bn_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Command
    input  wire logic              start,
    input  wire logic [6:0]        opcode,
    input  wire logic              subtract_sel,
    input  wire logic              gf2_convert,
    input  wire logic [1:0]        word_size_mode,
    input  wire logic [ADDR_W-1:0] x_operand_pointer,
    input  wire logic [ADDR_W-1:0] y_operand_pointer,
    input  wire logic [ADDR_W-1:0] z_operand_pointer,
    input  wire logic [ADDR_W-1:0] result_pointer,
    input  wire logic [LEN_W-1:0]  byte_length,
    // Status
    output logic                   busy,
    output logic                   done,
    output logic                   carry_flag,
    output logic                   zero_flag,
    output logic [3:0]             count_pointer,
    // Operand RAM
    output logic                   mem_re,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [WORD_W-1:0]      mem_wdata,
    input  wire logic [WORD_W-1:0] mem_rdata
);

    localparam int CW = LEN_W + 3;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    bn_pkg::bn_state_t state;
    bn_pkg::bn_kind_t  kind;
    bn_pkg::bn_kind_t  new_kind;
    logic [CW-1:0]     cyc;
    logic [CW-1:0]     last;
    logic [LEN_W-1:0]  ylen;
    logic [ADDR_W-1:0] x_ptr, y_ptr, z_ptr, r_ptr;
    logic [7:0]        fill_byte;
    logic              c_in;
    logic [WORD_W-1:0] chain;
    logic              zacc;
    logic [WORD_W-1:0] y_word, x_word, zc_word, reg_i;

    wire logic             mode_ok   = (word_size_mode == bn_pkg::MODE_W64_A) ||
                                       (word_size_mode == bn_pkg::MODE_W64_B);
    wire logic [LEN_W-1:0] new_ylen  = byte_length >> bn_pkg::WORD_SHIFT;
    wire logic             run       = (state == bn_pkg::ST_RUN);

    assign new_kind =
        (opcode == bn_pkg::OP_CARRY_ADDSUB && gf2_convert)  ? bn_pkg::K_XOR :
        (opcode == bn_pkg::OP_CARRY_ADDSUB && subtract_sel) ? bn_pkg::K_SUB :
        (opcode == bn_pkg::OP_CARRY_ADDSUB)                 ? bn_pkg::K_ADD :
        (opcode == bn_pkg::OP_XOR)                          ? bn_pkg::K_XOR :
        (opcode == bn_pkg::OP_TZC)                          ? bn_pkg::K_TZC :
        (opcode == bn_pkg::OP_LZC)                          ? bn_pkg::K_LZC :
        (opcode == bn_pkg::OP_FILL)                         ? bn_pkg::K_FILL :
        (opcode == bn_pkg::OP_CMP)                          ? bn_pkg::K_CMP :
        (opcode == bn_pkg::OP_MAC && gf2_convert)           ? bn_pkg::K_CLMAC :
        (opcode == bn_pkg::OP_MAC)                          ? bn_pkg::K_MAC :
        (opcode == bn_pkg::OP_CLMAC)                        ? bn_pkg::K_CLMAC :
        (opcode == bn_pkg::OP_SINGLE_WORD_MULTIPLY)                         ? bn_pkg::K_SINGLE_WORD_MULTIPLY :
                                                              bn_pkg::K_NONE;

    wire logic accept = (state == bn_pkg::ST_IDLE) && start && mode_ok &&
                        (new_kind != bn_pkg::K_NONE);

    wire logic is_mac   = (kind == bn_pkg::K_MAC) || (kind == bn_pkg::K_CLMAC);
    wire logic is_zc    = (kind == bn_pkg::K_TZC) || (kind == bn_pkg::K_LZC);
    wire logic is_single_word_multiply  = (kind == bn_pkg::K_SINGLE_WORD_MULTIPLY);
    wire logic is_slot  = !is_zc && !is_single_word_multiply;
    wire logic reads_yz = is_slot && (kind != bn_pkg::K_FILL);
    wire logic writes_r = is_slot && (kind != bn_pkg::K_CMP);

    // New operation length
    wire logic [CW-1:0] new_last =
        (new_kind == bn_pkg::K_TZC || new_kind == bn_pkg::K_LZC) ?
            CW'(bn_pkg::ZCNT_LAST) :
        (new_kind == bn_pkg::K_SINGLE_WORD_MULTIPLY) ? CW'(bn_pkg::SINGLE_WORD_MULTIPLY_LAST) :
            {1'b0, new_ylen, 2'b11};

    ////////////////////////////////////////////////////////////////////////////
    // Word sequencing

    wire logic [LEN_W:0]  k      = cyc[CW-1:2];
    wire logic [1:0]      ph     = cyc[1:0];
    wire logic            k_nz   = (k != '0);
    wire logic [LEN_W:0]  w      = is_mac ? k : k - (LEN_W+1)'(1);
    wire logic [LEN_W:0]  wr_idx = k - (LEN_W+1)'(1);
    wire logic            w_top  = is_mac && (k == {1'b0, ylen});
    wire logic            active = is_slot && (k_nz || is_mac);

    wire logic [ADDR_W-1:0] y_addr = y_ptr + ADDR_W'(w << bn_pkg::WORD_SHIFT);
    wire logic [ADDR_W-1:0] z_addr = z_ptr + ADDR_W'(w << bn_pkg::WORD_SHIFT);
    wire logic [ADDR_W-1:0] r_addr = r_ptr + ADDR_W'(wr_idx << bn_pkg::WORD_SHIFT);
    wire logic [ADDR_W-1:0] zc_top = (ylen == '0) ? z_ptr :
        z_ptr + ADDR_W'((ylen - LEN_W'(1)) << bn_pkg::WORD_SHIFT);

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic

    bn_mul_if #(.W(WORD_W)) mul_bus ();

    bn_mul #(.W(WORD_W)) u_mul (
        .bus (mul_bus.server)
    );

    // Y beyond its length is the zero extension of the MAC operand
    wire logic [WORD_W-1:0] y_eff = w_top ? '0 : y_word;
    wire logic [WORD_W-1:0] z_in  = mem_rdata;

    assign mul_bus.a         = is_single_word_multiply ? x_word : reg_i;
    assign mul_bus.b         = is_single_word_multiply ? mem_rdata : y_eff;
    assign mul_bus.carryless = (kind == bn_pkg::K_CLMAC);

    wire logic [WORD_W:0]     add_sum = {1'b0, y_eff} + {1'b0, z_in} +
                                        (WORD_W+1)'(chain[0]);
    wire logic [WORD_W:0]     sub_dif = {1'b0, y_eff} - {1'b0, z_in} -
                                        (WORD_W+1)'(chain[0]);
    wire logic [2*WORD_W-1:0] mac_sum = mul_bus.prod + {{WORD_W{1'b0}}, z_in} +
                                        {{WORD_W{1'b0}}, chain};

    logic [WORD_W-1:0] res;
    logic [WORD_W-1:0] res_chain;

    always_comb begin
        res       = '0;
        res_chain = chain;
        case (kind)
            bn_pkg::K_ADD: begin
                res       = add_sum[WORD_W-1:0];
                res_chain = WORD_W'(add_sum[WORD_W]);
            end
            bn_pkg::K_SUB, bn_pkg::K_CMP: begin
                res       = sub_dif[WORD_W-1:0];
                res_chain = WORD_W'(sub_dif[WORD_W]);
            end
            bn_pkg::K_XOR: res = y_eff ^ z_in;
            bn_pkg::K_FILL: res = {(WORD_W/8){fill_byte}};
            bn_pkg::K_MAC: begin
                res       = mac_sum[WORD_W-1:0];
                res_chain = mac_sum[2*WORD_W-1:WORD_W];
            end
            bn_pkg::K_CLMAC: begin
                res       = mul_bus.prod[WORD_W-1:0] ^ z_in ^ chain;
                res_chain = mul_bus.prod[2*WORD_W-1:WORD_W];
            end
            default: begin
                res       = '0;
                res_chain = chain;
            end
        endcase
    end

    wire logic exec_now  = run && (ph == bn_pkg::PH_EXEC) && active;
    wire logic write_now = run && (ph == bn_pkg::PH_EXEC) && k_nz && writes_r;
    wire logic final_now = run && (cyc == last);

    wire logic [WORD_W-1:0] next_chain = exec_now ? res_chain : chain;
    // Dropped MAC word is not part of the result
    wire logic next_zacc = (exec_now && k_nz) ? (zacc && (res == '0)) : zacc;

    ////////////////////////////////////////////////////////////////////////////
    // Zero counts and final flags

    function automatic logic [3:0] trail_zeros(input logic [7:0] v);
        logic [3:0] n;
        n = bn_pkg::ZCNT_SAT;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                n = 4'(i);
            end
        end
        return n;
    endfunction

    function automatic logic [3:0] lead_zeros(input logic [7:0] v);
        logic [3:0] n;
        n = bn_pkg::ZCNT_SAT;
        for (int i = 0; i < 8; i++) begin
            if (v[i]) begin
                n = 4'(7 - i);
            end
        end
        return n;
    endfunction

    wire logic [3:0] zc_count = (kind == bn_pkg::K_TZC) ?
        trail_zeros(zc_word[7:0]) :
        lead_zeros(zc_word[WORD_W-1:WORD_W-8]);

    // MAC top word is input carry plus last high word; only exactly one counts
    wire logic mac_one = c_in ? (next_chain == '0) :
                                (next_chain == WORD_W'(1));

    wire logic final_carry =
        (kind == bn_pkg::K_ADD) ? (c_in | next_chain[0]) :
        (kind == bn_pkg::K_SUB) ? (c_in ^ next_chain[0]) :
        (kind == bn_pkg::K_CMP) ? next_chain[0] :
        (kind == bn_pkg::K_MAC) ? mac_one : 1'b0;

    wire logic final_zero = is_zc ? (zc_count == 4'h0) : next_zacc;

    ////////////////////////////////////////////////////////////////////////////
    // RAM access selection

    wire logic rd_y   = run && (ph == bn_pkg::PH_RD_Y) && reads_yz && active && !w_top;
    wire logic rd_z   = run && (ph == bn_pkg::PH_RD_Z) && reads_yz && active;
    wire logic rd_zc  = run && is_zc && (cyc == CW'(bn_pkg::STEP_ISSUE));
    wire logic rd_x   = run && is_single_word_multiply && (cyc == CW'(bn_pkg::STEP_ISSUE));
    wire logic rd_y1  = run && is_single_word_multiply && (cyc == CW'(bn_pkg::STEP_ISSUE2));

    wire logic              next_mem_re   = rd_y | rd_z | rd_zc | rd_x | rd_y1;
    wire logic [ADDR_W-1:0] next_mem_addr =
        write_now ? r_addr :
        rd_y      ? y_addr :
        rd_z      ? z_addr :
        rd_zc     ? ((kind == bn_pkg::K_TZC) ? z_ptr : zc_top) :
        rd_x      ? x_ptr :
        rd_y1     ? y_ptr : mem_addr;

    assign busy = run;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= bn_pkg::ST_IDLE;
            cyc   <= '0;
            done  <= 1'b0;
        end else begin
            done <= final_now;
            if (accept) begin
                state <= bn_pkg::ST_RUN;
                cyc   <= '0;
            end else if (final_now) begin
                state <= bn_pkg::ST_IDLE;
            end else if (run) begin
                cyc <= cyc + CW'(1);
            end
        end
    end

    // Operand capture at start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            kind <= bn_pkg::K_NONE;
            last <= '0;
            ylen <= '0;
            {x_ptr, y_ptr, z_ptr, r_ptr} <= '0;
            fill_byte <= 8'h00;
            c_in <= 1'b0;
        end else if (accept) begin
            kind      <= new_kind;
            last      <= new_last;
            ylen      <= new_ylen;
            x_ptr     <= x_operand_pointer;
            y_ptr     <= y_operand_pointer;
            z_ptr     <= z_operand_pointer;
            r_ptr     <= result_pointer;
            fill_byte <= z_operand_pointer[7:0];
            c_in      <= carry_flag;
        end
    end

    // Running chain and data capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain <= '0;
            zacc  <= 1'b1;
            {y_word, x_word, zc_word, reg_i} <= '0;
        end else if (accept) begin
            chain <= '0;
            zacc  <= 1'b1;
        end else if (run) begin
            chain <= next_chain;
            zacc  <= next_zacc;
            // Y is held before the result word can overwrite it
            if (is_slot && ph == bn_pkg::PH_CAP_Y) y_word <= mem_rdata;
            if (is_single_word_multiply && cyc == CW'(bn_pkg::STEP_CAP)) x_word <= mem_rdata;
            if (is_zc && cyc == CW'(bn_pkg::STEP_CAP)) zc_word <= mem_rdata;
            if (is_single_word_multiply && final_now) reg_i <= mul_bus.prod[WORD_W-1:0];
        end
    end

    // Flags and count pointer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_flag    <= 1'b0;
            zero_flag     <= 1'b0;
            count_pointer <= 4'h0;
        end else if (final_now && !is_single_word_multiply) begin
            carry_flag <= final_carry;
            zero_flag  <= final_zero;
            if (is_zc) count_pointer <= zc_count;
        end
    end

    // RAM port registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_re    <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end else begin
            mem_re   <= next_mem_re;
            mem_we   <= write_now;
            mem_addr <= next_mem_addr;
            if (write_now) mem_wdata <= res;
        end
    end

endmodule

// >>> verif/bn_alu_asserts.sv
`timescale 1ns/10ps
module bn_alu_asserts #(
    parameter int WORD_W = 64,
    parameter int LEN_W  = 16,
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              arst_n,
    // Command
    input wire logic              start,
    input wire logic [6:0]        opcode,
    input wire logic [1:0]        word_size_mode,
    input wire logic [ADDR_W-1:0] z_operand_pointer,
    input wire logic [LEN_W-1:0]  byte_length,
    // Status and RAM
    input wire logic              busy,
    input wire logic              done,
    input wire logic              carry_flag,
    input wire logic              zero_flag,
    input wire logic [3:0]        count_pointer,
    input wire logic              mem_re,
    input wire logic              mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_wdata
);
    logic [6:0]        op_q;
    logic [ADDR_W-1:0] z_q;
    logic [LEN_W-1:0]  n_q;
    logic [LEN_W-1:0]  cnt;
    wire logic         mode_ok = word_size_mode == bn_pkg::MODE_W64_A
                                 || word_size_mode == bn_pkg::MODE_W64_B;
    wire logic         take    = start && !busy && mode_ok;
    wire logic         zc_op   = op_q == bn_pkg::OP_TZC || op_q == bn_pkg::OP_LZC;
    wire logic         mul_op  = op_q == bn_pkg::OP_SINGLE_WORD_MULTIPLY;

    // Cycles since the last accepted operation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_q <= '0;
            z_q  <= '0;
            n_q  <= '0;
            cnt  <= '0;
        end else begin
            cnt <= take ? '0 : cnt + 1'b1;
            if (take) begin
                op_q <= opcode;
                z_q  <= z_operand_pointer;
                n_q  <= ((byte_length >> 3) + LEN_W'(1)) << 2;
            end
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_op_latency: assert property (done && !zc_op && !mul_op |-> cnt == n_q)
        else $error("Operation latency wrong");
    a_zcnt_latency: assert property (done && zc_op |-> cnt == 16)
        else $error("Zero count latency wrong");
    a_mul_result: assert property (done && mul_op |-> cnt == 4 && $stable(carry_flag)
        && $stable(zero_flag)) else $error("Single word multiply timing or flags wrong");
    a_zcnt_flags: assert property (done && zc_op |-> !carry_flag && count_pointer <= 4'h8
        && zero_flag == (count_pointer == 4'h0)) else $error("Zero count flags wrong");
    a_fill_bytes: assert property (mem_we && op_q == bn_pkg::OP_FILL
        |-> mem_wdata == {8{z_q[7:0]}}) else $error("Fill data wrong");
    a_no_ram_write: assert property ((busy || done) && (zc_op || mul_op
        || op_q == bn_pkg::OP_CMP) |-> !mem_we) else $error("Unexpected RAM write");
    a_zcnt_read: assert property (take && opcode == bn_pkg::OP_TZC
        |-> ##2 mem_re && mem_addr == z_q) else $error("Trailing count read wrong");
    a_flag_change: assert property (!$stable(carry_flag) || !$stable(zero_flag) |-> done)
        else $error("Flags changed outside operation end");
    a_done_single: assert property (done |=> !done)
        else $error("Done longer than one cycle");
    a_bad_mode: assert property (start && !busy && !mode_ok |=> !busy)
        else $error("Start taken in an unsupported word size mode");

    c_mac: cover property (done && op_q == bn_pkg::OP_MAC && carry_flag);
    c_zc_sat: cover property (done && zc_op && count_pointer == 4'h8);
    c_cmp: cover property (done && op_q == bn_pkg::OP_CMP && carry_flag);
endmodule

bind bn_alu bn_alu_asserts #(.WORD_W(WORD_W), .LEN_W(LEN_W), .ADDR_W(ADDR_W)) u_bn_alu_asserts (
    .clk(clk), .arst_n(arst_n), .start(start), .opcode(opcode),
    .word_size_mode(word_size_mode), .z_operand_pointer(z_operand_pointer),
    .byte_length(byte_length), .busy(busy), .done(done), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .count_pointer(count_pointer), .mem_re(mem_re),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
);

// >>> verif/bn_ram.sv
`timescale 1ns/10ps
module bn_ram #(
    parameter int AW = 16,
    parameter int DW = 64
) (
    // Clock
    input  wire logic          clk,
    // Access
    input  wire logic          re,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:127];

    initial rdata = '0;

    // Data valid one cycle after the strobe only; otherwise it toggles
    always @(posedge clk) begin
        rdata <= re ? mem[addr[9:3]] : ~rdata;
        if (we) begin
            mem[addr[9:3]] <= wdata;
        end
    end
endmodule

// >>> verif/bn_alu_tb.sv
`timescale 1ns/10ps
module bn_alu_tb;
    localparam logic [15:0] A_Y = 16'h0000;
    localparam logic [15:0] A_Z = 16'h0100;
    localparam logic [15:0] A_R = 16'h0200;
    localparam logic [6:0]  ADD = bn_pkg::OP_CARRY_ADDSUB;
    logic        clk;
    logic        arst_n;
    logic        start;
    logic [6:0]  opcode;
    logic [6:0]  op;
    logic        sub_sel;
    logic        gf2;
    logic [1:0]  mode;
    logic [15:0] x_ptr, y_ptr, z_ptr, r_ptr, len, mem_addr;
    logic        busy, done, carry_flag, zero_flag, mem_re, mem_we;
    logic [3:0]  count_pointer;
    logic [63:0] mem_wdata, mem_rdata;
    int          num_errors;
    int          num_checks;
    logic [63:0] zc_val [6] = '{64'h8, 64'h1, 64'h100, 64'h0100000000000000,
                                64'h8000000000000000, 64'h00ff000000000000};
    logic [3:0]  zc_exp [6] = '{4'h3, 4'h0, 4'h8, 4'h7, 4'h0, 4'h8};

    bn_alu u_bn_alu (
        .clk(clk), .arst_n(arst_n), .start(start), .opcode(opcode),
        .subtract_sel(sub_sel), .gf2_convert(gf2), .word_size_mode(mode),
        .x_operand_pointer(x_ptr), .y_operand_pointer(y_ptr),
        .z_operand_pointer(z_ptr), .result_pointer(r_ptr), .byte_length(len),
        .busy(busy), .done(done), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .count_pointer(count_pointer), .mem_re(mem_re), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
    );
    bn_ram u_bn_ram (
        .clk(clk), .re(mem_re), .we(mem_we), .addr(mem_addr), .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic summarize();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic flags(input logic c, input logic z);
        check("carry_flag", 64'(c), 64'(carry_flag));
        check("zero_flag", 64'(z), 64'(zero_flag));
    endtask

    // Issue one operation and wait for its done pulse
    task automatic run(input logic [6:0] o, input logic s, input logic g, input logic [15:0] y,
                       input logic [15:0] z, input logic [15:0] r, input logic [15:0] l);
        int n;
        @(posedge clk);
        #1;
        {opcode, sub_sel, gf2, y_ptr, z_ptr, r_ptr, len} = {o, s, g, y, z, r, l};
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 100) begin
            num_errors++;
            $display("Error done expected 1 seen %b", done);
        end
        // Last result word commits at the edge that closes the done cycle
        @(posedge clk);
        #1;
    endtask

    task automatic mac(input logic [63:0] z1, input logic g, input logic [15:0] r);
        u_bn_ram.mem[96] = 64'h3;
        u_bn_ram.mem[0] = 64'h2;
        run(bn_pkg::OP_SINGLE_WORD_MULTIPLY, 1'b0, 1'b0, A_Y, A_Z, A_R, 16'h0008);
        u_bn_ram.mem[0] = 64'h4;
        u_bn_ram.mem[32] = 64'hfffffffffffffff8;
        u_bn_ram.mem[33] = z1;
        run(bn_pkg::OP_MAC, 1'b0, g, A_Y, A_Z, r, 16'h0008);
    endtask

    initial begin
        {start, opcode, sub_sel, gf2, op} = '0;
        {mode, y_ptr, z_ptr, r_ptr, len} = '0;
        x_ptr = 16'h0300;
        num_errors = 0;
        num_checks = 0;
        arst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        arst_n = 1'b1;
        mode = 2'h2;
        u_bn_ram.mem[0] = '1;
        u_bn_ram.mem[1] = '1;
        u_bn_ram.mem[32] = 64'h1;
        u_bn_ram.mem[33] = 64'h0;
        run(ADD, 1'b0, 1'b0, A_Y, A_Z, A_Y, 16'h0010);
        check("sum_w0", 64'h0, u_bn_ram.mem[0]);
        check("sum_w1", 64'h0, u_bn_ram.mem[1]);
        flags(1'b1, 1'b1);
        mode = 2'h0;
        u_bn_ram.mem[0] = 64'h5;
        u_bn_ram.mem[32] = 64'h3;
        run(ADD, 1'b0, 1'b0, A_Y, A_Z, A_R, 16'h0008);
        check("add_c", 64'h8, u_bn_ram.mem[64]);
        flags(1'b1, 1'b0);
        u_bn_ram.mem[0] = 64'h3;
        for (int i = 0; i < 2; i++) begin
            u_bn_ram.mem[32] = 64'h5;
            run(ADD, 1'b1, 1'b0, A_Y, A_Z, A_Z, 16'h0008);
            check("sub", 64'hfffffffffffffffe, u_bn_ram.mem[32]);
            flags(i != 0, 1'b0);
        end
        run(bn_pkg::OP_FILL, 1'b0, 1'b0, A_Y, 16'h0100, A_R, 16'h0010);
        flags(1'b0, 1'b1);
        run(bn_pkg::OP_FILL, 1'b0, 1'b0, A_Y, 16'h01a5, A_R, 16'h0010);
        check("fill_w1", 64'ha5a5a5a5a5a5a5a5, u_bn_ram.mem[65]);
        flags(1'b0, 1'b0);
        u_bn_ram.mem[32] = 64'h5;
        run(ADD, 1'b0, 1'b1, A_Y, A_Z, A_R, 16'h0008);
        check("xor", 64'h6, u_bn_ram.mem[64]);
        u_bn_ram.mem[64] = 64'h0;
        run(bn_pkg::OP_XOR, 1'b0, 1'b0, A_Y, A_Z, A_R, 16'h0008);
        check("xor_direct", 64'h6, u_bn_ram.mem[64]);
        flags(1'b0, 1'b0);
        run(bn_pkg::OP_CMP, 1'b0, 1'b0, A_Y, A_Z, A_R, 16'h0008);
        flags(1'b1, 1'b0);
        check("cmp_nowr", 64'h6, u_bn_ram.mem[64]);
        u_bn_ram.mem[64] = 64'h5;
        run(bn_pkg::OP_CMP, 1'b0, 1'b0, A_Z, A_R, A_Y, 16'h0008);
        flags(1'b0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            u_bn_ram.mem[32 + i / 3] = zc_val[i];
            op = i < 3 ? bn_pkg::OP_TZC : bn_pkg::OP_LZC;
            run(op, 1'b0, 1'b0, A_Y, A_Z, A_R, 16'h0010);
            check("count", 64'(zc_exp[i]), 64'(count_pointer));
            flags(1'b0, zc_exp[i] == 4'h0);
        end
        mac(64'h5, 1'b0, A_Z);
        check("mac", 64'h6, u_bn_ram.mem[32]);
        flags(1'b0, 1'b0);
        mac('1, 1'b0, A_R);
        check("mac_ovf", 64'h0, u_bn_ram.mem[64]);
        flags(1'b1, 1'b1);
        mac('1, 1'b0, A_R);
        flags(1'b0, 1'b1);
        mac(64'h5, 1'b1, A_R);
        check("clmac", 64'h5, u_bn_ram.mem[64]);
        flags(1'b0, 1'b0);
        mode = 2'h1;
        @(posedge clk);
        #1;
        {opcode, start} = {ADD, 1'b1};
        @(posedge clk);
        #1;
        start = 1'b0;
        check("busy_refused", 64'h0, 64'(busy));
        summarize();
    end

    // About 320 cycles of work; over twenty times that before giving up
    initial begin
        #28000;
        num_errors++;
        $display("Error watchdog expected done seen timeout");
        summarize();
    end
endmodule
